// >>> sdcp_device.sv
// SDRAM command-protocol device: decoder, banks, mode register and bursts
// What this block does
// - Latch 12-bit row at activate, 8-bit column at read/write, with bank bits.
// - All strobes high starts nothing; bursts in progress continue.
// - Chip select high disables the decoder; cycle acts as no-operation.
// - All strobes low writes the address pins into the mode register; bank pins are ignored.
// - Burst length A0-A2, type A3, read latency A4-A6, write burst A9.
// - First read word appears exactly read latency cycles after command.
// - Burst column wraps within aligned block in programmed order.
// - Outputs go high impedance at burst end unless a new read continues.
// - New read/write, same-bank precharge or burst stop cuts a read burst.
// - Write data taken from the command cycle; input stops at burst length.
// - Byte mask: reads two cycles later, writes same cycle.
// - Single precharge idles the bank after precharge time.
// - Auto-precharge bit times active and precharge intervals internally.
// - Read latency 2 or 3; burst 1,2,4,8, page; sequential or interleaved.
// - Auto refresh is strobes low with write enable high, all banks idle.
// - Precharge with auto-precharge bit high precharges all banks.
`timescale 1ns/1ps
module sdcp_device #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command pins
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [sdcp_pkg::ADDR_W-1:0] addr,
  input wire logic [sdcp_pkg::BANK_W-1:0] bankSel,
  input wire logic [sdcp_pkg::MASK_W-1:0] dqm,
  // Data pins
  input wire logic [sdcp_pkg::DATA_W-1:0] dqIn,
  output logic [sdcp_pkg::DATA_W-1:0] dqOut,
  output logic [sdcp_pkg::MASK_W-1:0] dqOeN,
  // Write stream to array side
  output logic wrValid,
  input wire logic wrReady,
  output logic [sdcp_pkg::DATA_W+sdcp_pkg::MASK_W+sdcp_pkg::COL_W+sdcp_pkg::ROW_W+1:0] wrWord,
  // Read data from array side, addressed by rdBank/rdRow/rdCol
  output logic [sdcp_pkg::BANK_W-1:0] rdBank,
  output logic [sdcp_pkg::ROW_W-1:0] rdRow,
  output logic [sdcp_pkg::COL_W-1:0] rdCol,
  input wire logic [sdcp_pkg::DATA_W-1:0] rdData,
  // Status
  output logic [11:0] modeReg,
  output logic [sdcp_pkg::NBANK-1:0] bankActive,
  output logic writeStall
);
  localparam int WW = sdcp_pkg::DATA_W + sdcp_pkg::MASK_W + sdcp_pkg::COL_W
                    + sdcp_pkg::ROW_W + sdcp_pkg::BANK_W;
  initial begin
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH too small");
  end

  // Next column within the wrapped burst block
  function automatic logic [7:0] burstCol(input logic [7:0] start, input logic [7:0] idx,
                                          input logic [2:0] bl, input logic inter);
    logic [7:0] msk;
    msk = 8'h00;
    case (bl)
      sdcp_pkg::BL_2: msk = 8'h01;
      sdcp_pkg::BL_4: msk = 8'h03;
      sdcp_pkg::BL_8: msk = 8'h07;
      sdcp_pkg::BL_PAGE: msk = 8'hff;
      default: msk = 8'h00;
    endcase
    if (inter && bl != sdcp_pkg::BL_PAGE)
      burstCol = (start & ~msk) | ((start ^ idx) & msk);
    else
      burstCol = (start & ~msk) | ((start + idx) & msk);
  endfunction : burstCol

  function automatic logic [8:0] burstLen(input logic [2:0] bl);
    case (bl)
      sdcp_pkg::BL_1: burstLen = 9'h001;
      sdcp_pkg::BL_2: burstLen = 9'h002;
      sdcp_pkg::BL_4: burstLen = 9'h004;
      sdcp_pkg::BL_8: burstLen = 9'h008;
      sdcp_pkg::BL_PAGE: burstLen = 9'(sdcp_pkg::PAGE_LEN);
      default: burstLen = 9'h001;
    endcase
  endfunction : burstLen

  sdcp_pkg::sdcp_cmd_t cmd;
  logic [2:0] bl, clSel;
  logic btInter, wrSingle;
  always_comb begin
    // Deselect and plain no-op start nothing
    cmd = csN ? sdcp_pkg::CMD_NOP : sdcp_pkg::sdcp_cmd_t'({rasN, casN, weN});
    if (!cke) cmd = sdcp_pkg::CMD_NOP;
    bl = modeReg[sdcp_pkg::MR_BL_HI:sdcp_pkg::MR_BL_LO];
    btInter = modeReg[sdcp_pkg::MR_BT];
    clSel = modeReg[sdcp_pkg::MR_CL_HI:sdcp_pkg::MR_CL_LO];
    wrSingle = modeReg[sdcp_pkg::MR_WBL];
  end

  // Bank state
  sdcp_pkg::sdcp_bank_t bkState [sdcp_pkg::NBANK];
  sdcp_pkg::sdcp_bank_t next_bkState [sdcp_pkg::NBANK];
  logic [sdcp_pkg::ROW_W-1:0] bkRow [sdcp_pkg::NBANK];
  logic [sdcp_pkg::ROW_W-1:0] next_bkRow [sdcp_pkg::NBANK];
  logic [sdcp_pkg::CNT_W-1:0] bkCnt [sdcp_pkg::NBANK];
  logic [sdcp_pkg::CNT_W-1:0] next_bkCnt [sdcp_pkg::NBANK];
  logic [sdcp_pkg::NBANK-1:0] bkAp, next_bkAp;
  logic [11:0] next_modeReg;
  logic burstDone;

  // Burst engine state
  sdcp_pkg::sdcp_burst_t bu, next_bu;
  logic [sdcp_pkg::BANK_W-1:0] buBank, next_buBank;
  logic [sdcp_pkg::COL_W-1:0] buStart, next_buStart;
  logic [8:0] buIdx, next_buIdx;
  logic [8:0] buLen, next_buLen;
  // Read output pipeline: depth covers latency 3
  logic [2:0] rdPipeV, next_rdPipeV;
  logic [sdcp_pkg::DATA_W-1:0] next_dqOut;
  logic [sdcp_pkg::MASK_W-1:0] dqmD1;
  logic [sdcp_pkg::MASK_W-1:0] next_dqOeN;

  always_comb begin
    next_modeReg = modeReg;
    next_bkAp = bkAp;
    burstDone = (bu != sdcp_pkg::BU_NONE) && (buIdx + 9'h001 >= buLen);
    for (int b = 0; b < sdcp_pkg::NBANK; b++) begin
      next_bkState[b] = bkState[b];
      next_bkRow[b] = bkRow[b];
      next_bkCnt[b] = (bkCnt[b] != '0) ? bkCnt[b] - 1'b1 : bkCnt[b];
      case (bkState[b])
        sdcp_pkg::BK_PRE: if (bkCnt[b] <= 1) next_bkState[b] = sdcp_pkg::BK_IDLE;
        sdcp_pkg::BK_ACTIVE:
          // Auto precharge begins once the burst ends and active time is met
          if (bkAp[b] && !(bu != sdcp_pkg::BU_NONE && buBank == 2'(b) && !burstDone)
              && bkCnt[b] <= 1) begin
            next_bkState[b] = sdcp_pkg::BK_PRE;
            next_bkCnt[b] = sdcp_pkg::CNT_W'(sdcp_pkg::RP_CYC);
            next_bkAp[b] = 1'b0;
          end
        default: ;
      endcase
    end
    case (cmd)
      sdcp_pkg::CMD_MODE: next_modeReg = addr;
      sdcp_pkg::CMD_ACT: begin
        next_bkState[bankSel] = sdcp_pkg::BK_ACTIVE;
        next_bkRow[bankSel] = addr;
        next_bkCnt[bankSel] = sdcp_pkg::CNT_W'(sdcp_pkg::RAS_CYC);
      end
      sdcp_pkg::CMD_PRE: begin
        for (int b = 0; b < sdcp_pkg::NBANK; b++) begin
          if ((addr[sdcp_pkg::AP_BIT] || bankSel == 2'(b))
              && bkState[b] == sdcp_pkg::BK_ACTIVE) begin
            next_bkState[b] = sdcp_pkg::BK_PRE;
            next_bkCnt[b] = sdcp_pkg::CNT_W'(sdcp_pkg::RP_CYC);
          end
        end
      end
      sdcp_pkg::CMD_RD, sdcp_pkg::CMD_WR:
        if (addr[sdcp_pkg::AP_BIT]) next_bkAp[bankSel] = 1'b1;
      default: ;
    endcase
  end

  always_comb begin
    next_bu = bu;
    next_buBank = buBank;
    next_buStart = buStart;
    next_buLen = buLen;
    next_buIdx = buIdx + 9'h001;
    if (burstDone) next_bu = sdcp_pkg::BU_NONE;
    case (cmd)
      sdcp_pkg::CMD_RD, sdcp_pkg::CMD_WR: begin
        // New column command cuts any burst short
        next_bu = (cmd == sdcp_pkg::CMD_RD) ? sdcp_pkg::BU_READ : sdcp_pkg::BU_WRITE;
        next_buBank = bankSel;
        next_buStart = addr[sdcp_pkg::COL_W-1:0];
        next_buIdx = 9'h001;
        next_buLen = (cmd == sdcp_pkg::CMD_WR && wrSingle) ? 9'h001 : burstLen(bl);
        if (next_buLen == 9'h001) next_bu = sdcp_pkg::BU_NONE;
      end
      sdcp_pkg::CMD_STOP: next_bu = sdcp_pkg::BU_NONE;
      sdcp_pkg::CMD_PRE:
        if (addr[sdcp_pkg::AP_BIT] || bankSel == buBank) next_bu = sdcp_pkg::BU_NONE;
      default: ;
    endcase
  end

  // Array access for the current beat
  logic beatRd, beatWr;
  logic [sdcp_pkg::BANK_W-1:0] beatBank;
  logic [sdcp_pkg::COL_W-1:0] beatCol;
  logic fifoReady;
  always_comb begin
    beatRd = (cmd == sdcp_pkg::CMD_RD) || (bu == sdcp_pkg::BU_READ && cmd != sdcp_pkg::CMD_STOP
             && cmd != sdcp_pkg::CMD_WR);
    beatWr = (cmd == sdcp_pkg::CMD_WR) || (bu == sdcp_pkg::BU_WRITE
             && !(cmd inside {sdcp_pkg::CMD_RD, sdcp_pkg::CMD_STOP, sdcp_pkg::CMD_PRE}));
    beatBank = (cmd inside {sdcp_pkg::CMD_RD, sdcp_pkg::CMD_WR}) ? bankSel : buBank;
    beatCol = (cmd inside {sdcp_pkg::CMD_RD, sdcp_pkg::CMD_WR}) ? addr[sdcp_pkg::COL_W-1:0]
              : burstCol(buStart, buIdx[7:0], bl, btInter);
    // Read pipe: a beat enters at stage 1 and drives the outputs from stage clSel-1
    next_rdPipeV = {rdPipeV[1:0], beatRd};
    next_dqOut = rdData;
    // Byte mask on reads acts two cycles after sampling
    for (int i = 0; i < sdcp_pkg::MASK_W; i++)
      next_dqOeN[i] = !((clSel == sdcp_pkg::CL_3 ? rdPipeV[1] : rdPipeV[0])
                        && !dqmD1[i]);
  end

  // Read data path registered once more to match latency
  logic [sdcp_pkg::DATA_W-1:0] rdStage;
  logic [sdcp_pkg::BANK_W-1:0] next_rdBank;
  logic [sdcp_pkg::ROW_W-1:0] next_rdRow;
  logic [sdcp_pkg::COL_W-1:0] next_rdCol;
  always_comb begin
    next_rdBank = beatBank;
    next_rdRow = bkRow[beatBank];
    next_rdCol = beatCol;
  end

  sdcp_fifo #(.WIDTH(WW), .DEPTH(FIFO_DEPTH)) u_wrFifo (
    .clk(clk),
    .reset(reset),
    .inValid(beatWr && dqm != {sdcp_pkg::MASK_W{1'b1}}),
    .inReady(fifoReady),
    .inData({dqIn, dqm, beatCol, bkRow[beatBank], beatBank}),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData(wrWord)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      modeReg <= sdcp_pkg::MODE_RESET;
      bkAp <= '0;
      bu <= sdcp_pkg::BU_NONE;
      buBank <= '0;
      buStart <= '0;
      buIdx <= '0;
      buLen <= 9'h001;
      rdPipeV <= '0;
      dqOut <= '0;
      dqOeN <= '1;
      dqmD1 <= '1;
      rdBank <= '0;
      rdRow <= '0;
      rdCol <= '0;
      rdStage <= '0;
      bankActive <= '0;
      writeStall <= 1'b0;
      for (int b = 0; b < sdcp_pkg::NBANK; b++) begin
        bkState[b] <= sdcp_pkg::BK_IDLE;
        bkRow[b] <= '0;
        bkCnt[b] <= '0;
      end
    end else begin
      modeReg <= next_modeReg;
      bkAp <= next_bkAp;
      bu <= next_bu;
      buBank <= next_buBank;
      buStart <= next_buStart;
      buIdx <= next_buIdx;
      buLen <= next_buLen;
      rdPipeV <= next_rdPipeV;
      rdStage <= rdData;
      dqOut <= (clSel == sdcp_pkg::CL_3) ? rdStage : next_dqOut;
      dqOeN <= next_dqOeN;
      dqmD1 <= dqm;
      rdBank <= next_rdBank;
      rdRow <= next_rdRow;
      rdCol <= next_rdCol;
      writeStall <= !fifoReady;
      for (int b = 0; b < sdcp_pkg::NBANK; b++) begin
        bkState[b] <= next_bkState[b];
        bkRow[b] <= next_bkRow[b];
        bkCnt[b] <= next_bkCnt[b];
        bankActive[b] <= next_bkState[b] == sdcp_pkg::BK_ACTIVE;
      end
    end
  end

  AST_MODE_WRITE: assert property (@(posedge clk) disable iff (reset)
    (cmd == sdcp_pkg::CMD_MODE) |=> (modeReg == $past(addr)))
    else $error("mode register not captured");
  AST_DESELECT: assert property (@(posedge clk) disable iff (reset)
    (csN && bu == sdcp_pkg::BU_NONE && bankActive == '0) |=> $stable(bankActive))
    else $error("deselect changed bank state");
  AST_ROW_LATCH: assert property (@(posedge clk) disable iff (reset)
    (cmd == sdcp_pkg::CMD_ACT) |=> (bkRow[$past(bankSel)] == $past(addr)))
    else $error("row not latched");
  AST_READ_LAT2: assert property (@(posedge clk) disable iff (reset)
    (cmd == sdcp_pkg::CMD_RD && clSel == sdcp_pkg::CL_2 && dqm == '0)
    ##1 (dqm == '0 && clSel == sdcp_pkg::CL_2) |=> (dqOeN == '0))
    else $error("read data not driven at latency two");
  AST_IDLE_HIZ: assert property (@(posedge clk) disable iff (reset)
    (rdPipeV == '0) |=> (dqOeN == '1))
    else $error("outputs driven without read");
  AST_PRECHARGE: assert property (@(posedge clk) disable iff (reset)
    (cmd == sdcp_pkg::CMD_PRE && bkState[bankSel] == sdcp_pkg::BK_ACTIVE)
    |=> (bkState[$past(bankSel)] == sdcp_pkg::BK_PRE))
    else $error("precharge not started");
  AST_STOP: assert property (@(posedge clk) disable iff (reset)
    (cmd == sdcp_pkg::CMD_STOP) |=> (bu == sdcp_pkg::BU_NONE))
    else $error("burst stop ignored");
  AST_WRITE_MASK: assert property (@(posedge clk) disable iff (reset)
    (beatWr && dqm == '1) |-> !u_wrFifo.push)
    else $error("masked write accepted");
  AST_ALL_IDLE: assert property (@(posedge clk) disable iff (reset)
    (cmd inside {sdcp_pkg::CMD_MODE, sdcp_pkg::CMD_REF}) |-> (bankActive == '0))
    else $error("refresh or mode write with a bank active");
endmodule : sdcp_device

// >>> sdcp_pkg.sv
// Constants and types shared by the SDRAM command-protocol device model
package sdcp_pkg;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int BANK_W = 2;
  localparam int NBANK = 4;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int MASK_W = 2;
  // Mode register field positions and auto-precharge address bit
  localparam int MR_BL_LO = 0;
  localparam int MR_BL_HI = 2;
  localparam int MR_BT = 3;
  localparam int MR_CL_LO = 4;
  localparam int MR_CL_HI = 6;
  localparam int MR_WBL = 9;
  localparam int AP_BIT = 10;
  // Burst length and read latency codes, reset mode, page length
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_3 = 3'h3;
  localparam logic [11:0] MODE_RESET = 12'h020;
  localparam int PAGE_LEN = 256;
  // Timing, in ns, and derived cycle counts at 25 MHz
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_RAS_MIN_NS = 42;
  localparam int ROW_PRECHARGE_NS = 18;
  localparam int MODE_WRITE_CYC = 2;
  localparam int RAS_CYC = (T_RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DQM_RD_LAT = 2;
  localparam int CNT_W = 4;
  // Command codes {rasN, casN, weN}
  typedef enum logic [2:0] {
    CMD_MODE = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
    CMD_WR = 3'h4, CMD_RD = 3'h5, CMD_STOP = 3'h6, CMD_NOP = 3'h7
  } sdcp_cmd_t;
  typedef enum logic [1:0] {
    BK_IDLE = 2'h0, BK_ACTIVE = 2'h1, BK_PRE = 2'h2
  } sdcp_bank_t;
  typedef enum logic [1:0] {
    BU_NONE = 2'h0, BU_READ = 2'h1, BU_WRITE = 2'h2
  } sdcp_burst_t;
endpackage : sdcp_pkg

// >>> sdcp_fifo.sv
// Synchronous FIFO with valid/ready handshakes on both sides
`timescale 1ns/1ps
module sdcp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic push, pop;
  always_comb begin
    inReady = (wrPtr - rdPtr) != (AW+1)'(DEPTH);
    outValid = wrPtr != rdPtr;
    outData = mem[rdPtr[AW-1:0]];
    push = inValid && inReady;
    pop = outValid && outReady;
    next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem[wrPtr[AW-1:0]] <= inData;
  end
endmodule : sdcp_fifo

// >>> sdcp_ctrl.sv
// Controller model driving command, mask and write-data pins
`timescale 1ns/1ps
module sdcp_ctrl #(
  parameter int INIT_CYC = 5000,
  parameter int RCD_CYC = 1
) (
  // Clock
  input wire logic clk,
  // Command pins
  output logic cke,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [sdcp_pkg::ADDR_W-1:0] addr,
  output logic [sdcp_pkg::BANK_W-1:0] bankSel,
  output logic [sdcp_pkg::MASK_W-1:0] dqm,
  // Write data
  output logic [sdcp_pkg::DATA_W-1:0] dqIn
);
  initial begin
    cke = 1'b1;
    csN = 1'b0;
    {rasN, casN, weN} = sdcp_pkg::CMD_NOP;
    addr = 12'h000;
    bankSel = 2'h0;
    dqm = 2'b11;
    dqIn = 16'h0000;
  end

  // One command cycle, then no-operation with scrambled address and data
  task automatic issue(input logic cs, input sdcp_pkg::sdcp_cmd_t c, input logic [11:0] a,
                       input logic [1:0] b);
    @(posedge clk);
    csN <= cs;
    {rasN, casN, weN} <= c;
    addr <= a;
    bankSel <= b;
    @(posedge clk);
    csN <= 1'b0;
    {rasN, casN, weN} <= sdcp_pkg::CMD_NOP;
    addr <= ~a;
    dqIn <= ~dqIn;
  endtask : issue

  task automatic mode_write(input logic [11:0] mode);
    issue(1'b0, sdcp_pkg::CMD_MODE, mode & 12'h27f, 2'h0);
    repeat (sdcp_pkg::MODE_WRITE_CYC - 1) @(posedge clk);
  endtask : mode_write

  task automatic clken(input logic v);
    @(posedge clk);
    cke <= v;
  endtask : clken

  task automatic init(input logic [11:0] mode);
    dqm <= 2'b11;
    repeat (INIT_CYC) @(posedge clk);
    issue(1'b0, sdcp_pkg::CMD_PRE, 12'h400, 2'h0);
    repeat (2) issue(1'b0, sdcp_pkg::CMD_REF, 12'h000, 2'h0);
    mode_write(mode);
    dqm <= 2'b00;
  endtask : init

  task automatic act(input logic [1:0] b, input logic [11:0] row);
    issue(1'b0, sdcp_pkg::CMD_ACT, row, b);
    repeat (RCD_CYC) @(posedge clk);
  endtask : act

  task automatic pre(input logic [1:0] b, input logic all);
    issue(1'b0, sdcp_pkg::CMD_PRE, {1'b0, all, 10'h000}, b);
    @(posedge clk);
  endtask : pre

  task automatic mask(input logic [1:0] v);
    @(posedge clk);
    dqm <= v;
  endtask : mask

  // Write burst of n beats, beat m masked
  task automatic wr(input logic [1:0] b, input logic [7:0] col, input logic [15:0] d,
                    input int n, input int m);
    @(posedge clk);
    {rasN, casN, weN} <= sdcp_pkg::CMD_WR;
    addr <= {4'h0, col};
    bankSel <= b;
    dqIn <= d;
    for (int i = 1; i <= n; i++) begin
      @(posedge clk);
      {rasN, casN, weN} <= sdcp_pkg::CMD_NOP;
      dqIn <= (i < n) ? d + 16'(i) : ~dqIn;
      dqm <= (i == m) ? 2'b11 : 2'b00;
    end
  endtask : wr
endmodule : sdcp_ctrl

// >>> testbench.sv
// Self-checking bench for the SDRAM command-protocol device
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  logic clk;
  logic reset;
  logic wrReady;
  logic cke, csN, rasN, casN, weN;
  logic [sdcp_pkg::ADDR_W-1:0] addr;
  logic [sdcp_pkg::BANK_W-1:0] bankSel;
  logic [sdcp_pkg::MASK_W-1:0] dqm;
  logic [sdcp_pkg::DATA_W-1:0] dqIn, dqOut, rdData;
  logic [sdcp_pkg::MASK_W-1:0] dqOeN;
  logic wrValid, writeStall;
  logic [sdcp_pkg::DATA_W+sdcp_pkg::MASK_W+sdcp_pkg::COL_W+sdcp_pkg::ROW_W+1:0] wrWord;
  logic [39:0] wq[$];
  logic [sdcp_pkg::BANK_W-1:0] rdBank;
  logic [sdcp_pkg::ROW_W-1:0] rdRow;
  logic [sdcp_pkg::COL_W-1:0] rdCol;
  logic [11:0] modeReg;
  logic [sdcp_pkg::NBANK-1:0] bankActive;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;

  sdcp_ctrl u_sdcp_ctrl (.clk(clk), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
    .weN(weN), .addr(addr), .bankSel(bankSel), .dqm(dqm), .dqIn(dqIn));
  sdcp_device #(.FIFO_DEPTH(16)) u_sdcp_device (.clk(clk), .reset(reset), .cke(cke),
    .csN(csN), .rasN(rasN), .casN(casN), .weN(weN), .addr(addr), .bankSel(bankSel),
    .dqm(dqm), .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN), .wrValid(wrValid),
    .wrReady(wrReady), .wrWord(wrWord), .rdBank(rdBank), .rdRow(rdRow), .rdCol(rdCol),
    .rdData(rdData), .modeReg(modeReg), .bankActive(bankActive), .writeStall(writeStall));

  // Array reply encodes its own address
  assign rdData = {rdBank, rdRow[5:0], rdCol};

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (wrValid === 1'b1 && wrReady === 1'b1) wq.push_back(wrWord);
    if (cycles == 30000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic t_modes();
    logic [11:0] modes [4] = '{12'h022, 12'h02a, 12'h032, 12'h023};
    int bl, off;
    logic [7:0] c;
    for (int k = 0; k < 4; k++) begin
      u_sdcp_ctrl.mode_write(modes[k]);
      `CHK(modeReg, modes[k])
      u_sdcp_ctrl.act(2'h1, 12'h025);
      `CHK(bankActive, 4'b0010)
      bl = 1 << modes[k][2:0];
      u_sdcp_ctrl.issue(1'b0, sdcp_pkg::CMD_RD, 12'h035, 2'h1);
      repeat (modes[k][6:4] - 2) @(posedge clk);
      for (int i = 0; i < bl; i++) begin
        @(posedge clk);
        #1;
        off = modes[k][3] ? ((8'h35 % bl) ^ i) : ((8'h35 + i) % bl);
        c = 8'(8'h35 - 8'h35 % bl + off);
        `CHK(dqOut, {2'h1, 6'h25, c})
        `CHK(dqOeN, 2'b00)
      end
      @(posedge clk);
      #1;
      `CHK(dqOeN, 2'b11)
      u_sdcp_ctrl.pre(2'h1, 1'b0);
      `CHK(bankActive, 4'b0000)
    end
  endtask : t_modes

  task automatic t_cut();
    u_sdcp_ctrl.mode_write(12'h023);
    u_sdcp_ctrl.act(2'h1, 12'h025);
    u_sdcp_ctrl.issue(1'b0, sdcp_pkg::CMD_RD, 12'h000, 2'h1);
    u_sdcp_ctrl.issue(1'b0, sdcp_pkg::CMD_STOP, 12'h000, 2'h1);
    repeat (4) @(posedge clk);
    #1;
    `CHK(dqOeN, 2'b11)
    u_sdcp_ctrl.pre(2'h1, 1'b0);
    u_sdcp_ctrl.mode_write(12'h022);
    u_sdcp_ctrl.act(2'h1, 12'h025);
    u_sdcp_ctrl.issue(1'b0, sdcp_pkg::CMD_RD, 12'h000, 2'h1);
    u_sdcp_ctrl.mask(2'b11);
    u_sdcp_ctrl.mask(2'b00);
    @(posedge clk);
    #1;
    `CHK(dqOeN, 2'b11)
    @(posedge clk);
    #1;
    `CHK(dqOeN, 2'b00)
    u_sdcp_ctrl.pre(2'h1, 1'b0);
    u_sdcp_ctrl.issue(1'b1, sdcp_pkg::CMD_MODE, 12'h031, 2'h0);
    repeat (2) @(posedge clk);
    `CHK(modeReg, 12'h022)
    u_sdcp_ctrl.clken(1'b0);
    u_sdcp_ctrl.issue(1'b0, sdcp_pkg::CMD_MODE, 12'h031, 2'h0);
    u_sdcp_ctrl.clken(1'b1);
    repeat (2) @(posedge clk);
    `CHK(modeReg, 12'h022)
  endtask : t_cut

  task automatic t_write();
    u_sdcp_ctrl.act(2'h2, 12'h010);
    wq.delete();
    u_sdcp_ctrl.wr(2'h2, 8'h0c, 16'h1230, 4, 2);
    repeat (4) @(posedge clk);
    `CHK(wq.size(), 3)
    `CHK(wq[0][39:24], 16'h1230)
    `CHK(wq[1][39:24], 16'h1231)
    `CHK(wq[2][39:24], 16'h1233)
    `CHK(wq[2][21:14], 8'h0f)
    u_sdcp_ctrl.pre(2'h2, 1'b0);
    u_sdcp_ctrl.mode_write(12'h027);
    u_sdcp_ctrl.act(2'h2, 12'h010);
    wrReady <= 1'b0;
    u_sdcp_ctrl.wr(2'h2, 8'h00, 16'h4000, 20, 99);
    u_sdcp_ctrl.issue(1'b0, sdcp_pkg::CMD_STOP, 12'h000, 2'h2);
    `CHK(writeStall, 1'b1)
    wq.delete();
    wrReady <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(wq.size(), 16)
    `CHK(writeStall, 1'b0)
    u_sdcp_ctrl.pre(2'h0, 1'b1);
    `CHK(bankActive, 4'b0000)
  endtask : t_write

  task automatic t_auto();
    u_sdcp_ctrl.mode_write(12'h022);
    u_sdcp_ctrl.act(2'h3, 12'h0aa);
    u_sdcp_ctrl.issue(1'b0, sdcp_pkg::CMD_RD, 12'h404, 2'h3);
    #1;
    `CHK(bankActive, 4'b1000)
    repeat (2) @(posedge clk);
    #1;
    `CHK(bankActive, 4'b1000)
    @(posedge clk);
    #1;
    `CHK(bankActive, 4'b0000)
  endtask : t_auto

  initial begin
    reset = 1'b1;
    wrReady = 1'b1;
    repeat (8) @(posedge clk);
    `CHK(modeReg, sdcp_pkg::MODE_RESET)
    `CHK(dqOeN, 2'b11)
    reset <= 1'b0;
    u_sdcp_ctrl.init(12'h022);
    `CHK(modeReg, 12'h022)
    t_modes();
    t_cut();
    t_write();
    t_auto();
    wrap_up();
  end
endmodule : testbench
